/* rtl/tlic_pkg.sv */
// Constants, register layout and vectors of the interrupt controller
// What this block does
// - Each source has one priority bit: 0 low level, 1 high level.
// - A pending enabled high request preempts a running low handler.
// - No vector call at all while a high handler is in progress.
// - High-level requests win over low ones polled in the same cycle.
// - Equal level ties resolve by fixed order, slot 0 first, slot 9 last.
// - Each source has its own enable bit; cleared means never called.
// - Main enable bit 7 gates all requests globally.
// - Main enable layout: t2 b5, uart b4, t1 b3, ext1 b2, t0 b1, ext0 b0.
// - Aux enable layout: uart2 b4, i2c b1, usb b0.
// - Main priority layout mirrors the main enable layout, bits 5..0.
// - Aux priority layout: uart2 b4, i2c b1, usb b0.
// - Flags sampled once per machine cycle, evaluated at the last clock of that same machine cycle.
// - Withhold call while equal or higher level handler is in progress.
// - Call only in the final machine cycle of the current instruction.
// - No call during return or access to enable or priority registers.
// - Blocked requests are not remembered; every poll is fresh.
// - Call makes core push the program counter and load the vector.
// - Vectors: 0003h,000Bh,0013h,001Bh,0023h,002Bh,0033h,0043h,004Bh.
// - Return from handler clears the current level's in-progress state.
// - Plain subroutine return leaves the in-progress state untouched.
// - An enabled request or reset ends core idle.
// - Edge external flag cleared on call; level flag follows its pin.
package tlic_pkg;
  localparam int          NUM_SLOTS       = 10;
  localparam int          SLOT_W          = 4;
  // Register addresses on the plain register port
  localparam logic [1:0]  ADDR_MAIN_EN    = 2'h0;
  localparam logic [1:0]  ADDR_AUX_EN     = 2'h1;
  localparam logic [1:0]  ADDR_MAIN_PRIO  = 2'h2;
  localparam logic [1:0]  ADDR_AUX_PRIO   = 2'h3;
  localparam logic [7:0]  REG_RESET       = 8'h00;
  localparam logic [7:0]  MAIN_EN_MASK    = 8'hBF;
  localparam logic [7:0]  MAIN_PRIO_MASK  = 8'h3F;
  localparam logic [7:0]  AUX_MASK        = 8'h13;
  // Bit positions
  localparam int          BIT_GLOBAL      = 7;
  localparam int          BIT_T2          = 5;
  localparam int          BIT_UART        = 4;
  localparam int          BIT_T1          = 3;
  localparam int          BIT_EXT1        = 2;
  localparam int          BIT_T0          = 1;
  localparam int          BIT_EXT0        = 0;
  localparam int          BIT_UART2       = 4;
  localparam int          BIT_I2C         = 1;
  localparam int          BIT_USB         = 0;
  // Polling slots, 0 polled first
  localparam logic [3:0]  SLOT_EXT0       = 4'h0;
  localparam logic [3:0]  SLOT_UART2      = 4'h1;
  localparam logic [3:0]  SLOT_T0         = 4'h2;
  localparam logic [3:0]  SLOT_I2C        = 4'h3;
  localparam logic [3:0]  SLOT_EXT1       = 4'h4;
  localparam logic [3:0]  SLOT_RSVD       = 4'h5;
  localparam logic [3:0]  SLOT_T1         = 4'h6;
  localparam logic [3:0]  SLOT_USB        = 4'h7;
  localparam logic [3:0]  SLOT_UART       = 4'h8;
  localparam logic [3:0]  SLOT_T2         = 4'h9;
  // Vector addresses per source
  localparam logic [15:0] VEC_EXT0        = 16'h0003;
  localparam logic [15:0] VEC_T0          = 16'h000B;
  localparam logic [15:0] VEC_EXT1        = 16'h0013;
  localparam logic [15:0] VEC_T1          = 16'h001B;
  localparam logic [15:0] VEC_UART        = 16'h0023;
  localparam logic [15:0] VEC_T2          = 16'h002B;
  localparam logic [15:0] VEC_USB         = 16'h0033;
  localparam logic [15:0] VEC_I2C         = 16'h0043;
  localparam logic [15:0] VEC_UART2       = 16'h004B;
  // Core clocks per machine cycle and the sampling phase within it
  localparam int          MC_CLKS         = 12;
  localparam logic [3:0]  MC_LAST         = 4'(MC_CLKS - 1);
  localparam logic [3:0]  SAMPLE_PHASE    = 4'h9;
endpackage : tlic_pkg

/* rtl/tlic_arbiter.sv */
// Fixed-order two-level request picker with registered result
`timescale 1ns/100ps
module tlic_arbiter
  import tlic_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 load_in,
  input  wire logic [NUM_SLOTS-1:0] req_in,
  input  wire logic [NUM_SLOTS-1:0] prio_in,
  output logic                      hit_out,
  output logic                      hit_high_out,
  output logic [SLOT_W-1:0]         slot_out
);
  logic              hit_r,  hit_nxt;
  logic              high_r, high_nxt;
  logic [SLOT_W-1:0] slot_r, slot_nxt;
  logic [NUM_SLOTS-1:0] hi_req, lo_req;

  // First set bit in fixed polling order
  function automatic logic [SLOT_W-1:0] first_set(
    input logic [NUM_SLOTS-1:0] v);
    logic [SLOT_W-1:0] s;
    s = '0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (v[i]) s = SLOT_W'(i);
    end
    return s;
  endfunction

  // Split by level, high wins
  always_comb begin
    hi_req   = req_in & prio_in;
    lo_req   = req_in & ~prio_in;
    hit_nxt  = hit_r;
    high_nxt = high_r;
    slot_nxt = slot_r;
    if (load_in) begin
      hit_nxt  = |req_in;
      high_nxt = |hi_req;
      slot_nxt = (|hi_req) ? first_set(hi_req) : first_set(lo_req);
    end
  end

  // Result registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hit_r  <= 1'b0;
      high_r <= 1'b0;
      slot_r <= '0;
    end else begin
      hit_r  <= hit_nxt;
      high_r <= high_nxt;
      slot_r <= slot_nxt;
    end
  end

  assign hit_out      = hit_r;
  assign hit_high_out = high_r;
  assign slot_out     = slot_r;
endmodule : tlic_arbiter

/* rtl/tlic_ctrl.sv */
// Two-level interrupt controller top: registers, sampling, vector call
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module tlic_ctrl
  import tlic_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Register port
  input  wire logic [1:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [7:0]       reg_rdata_out,
  // Request flags from sources
  input  wire logic        ext_request_zero_in,
  input  wire logic        ext_request_one_in,
  input  wire logic        ext0_edge_mode_in,
  input  wire logic        ext1_edge_mode_in,
  input  wire logic        timer0_flag_in,
  input  wire logic        timer1_flag_in,
  input  wire logic        timer2_flag_in,
  input  wire logic        uart_flag_in,
  input  wire logic        uart2_flag_in,
  input  wire logic        i2c_flag_in,
  input  wire logic        usb_flag_in,
  // Core status
  input  wire logic        instr_last_cycle_in,
  input  wire logic        instr_blocks_in,
  input  wire logic        return_from_handler_in,
  input  wire logic        core_idle_in,
  // Core commands
  output logic             hardware_vector_call_out,
  output logic [15:0]      vector_addr_out,
  output logic             ext0_flag_clear_out,
  output logic             ext1_flag_clear_out,
  output logic             idle_wake_out,
  output logic             low_active_out,
  output logic             high_active_out
);
  // Software registers
  logic [7:0]  main_irq_enable_r, main_irq_enable_nxt;
  logic [7:0]  aux_irq_enable_r,  aux_irq_enable_nxt;
  logic [7:0]  main_irq_prio_r,   main_irq_prio_nxt;
  logic [7:0]  aux_irq_prio_r,    aux_irq_prio_nxt;
  logic [7:0]  rdata_r,           rdata_nxt;
  // Machine cycle timing
  logic [3:0]  phase_r,           phase_nxt;
  // Sample and in-progress state
  logic [NUM_SLOTS-1:0] sample_r, sample_nxt;
  logic        low_active_r,      low_active_nxt;
  logic        high_active_r,     high_active_nxt;
  logic        call_r,            call_nxt;
  logic [15:0] vec_r,             vec_nxt;
  logic        clr0_r,            clr0_nxt;
  logic        clr1_r,            clr1_nxt;
  logic        wake_r,            wake_nxt;

  logic [NUM_SLOTS-1:0] live_req, en_vec, prio_vec;
  logic        mc_end, sample_now, arb_hit, arb_high, allow, take;
  logic [SLOT_W-1:0] arb_slot;

  // Vector lookup per polling slot
  function automatic logic [15:0] slot_vector(input logic [SLOT_W-1:0] s);
    logic [15:0] v;
    v = VEC_EXT0;
    unique case (s)
      SLOT_EXT0:  v = VEC_EXT0;
      SLOT_UART2: v = VEC_UART2;
      SLOT_T0:    v = VEC_T0;
      SLOT_I2C:   v = VEC_I2C;
      SLOT_EXT1:  v = VEC_EXT1;
      SLOT_T1:    v = VEC_T1;
      SLOT_USB:   v = VEC_USB;
      SLOT_UART:  v = VEC_UART;
      SLOT_T2:    v = VEC_T2;
      default:    v = VEC_EXT0;   // Reserved slot never wins
    endcase
    return v;
  endfunction

  // Per-slot enable and priority vectors
  always_comb begin
    en_vec = '0;
    prio_vec = '0;
    en_vec[SLOT_EXT0]  = main_irq_enable_r[BIT_EXT0];
    en_vec[SLOT_T0]    = main_irq_enable_r[BIT_T0];
    en_vec[SLOT_EXT1]  = main_irq_enable_r[BIT_EXT1];
    en_vec[SLOT_T1]    = main_irq_enable_r[BIT_T1];
    en_vec[SLOT_UART]  = main_irq_enable_r[BIT_UART];
    en_vec[SLOT_T2]    = main_irq_enable_r[BIT_T2];
    en_vec[SLOT_UART2] = aux_irq_enable_r[BIT_UART2];
    en_vec[SLOT_I2C]   = aux_irq_enable_r[BIT_I2C];
    en_vec[SLOT_USB]   = aux_irq_enable_r[BIT_USB];
    prio_vec[SLOT_EXT0]  = main_irq_prio_r[BIT_EXT0];
    prio_vec[SLOT_T0]    = main_irq_prio_r[BIT_T0];
    prio_vec[SLOT_EXT1]  = main_irq_prio_r[BIT_EXT1];
    prio_vec[SLOT_T1]    = main_irq_prio_r[BIT_T1];
    prio_vec[SLOT_UART]  = main_irq_prio_r[BIT_UART];
    prio_vec[SLOT_T2]    = main_irq_prio_r[BIT_T2];
    prio_vec[SLOT_UART2] = aux_irq_prio_r[BIT_UART2];
    prio_vec[SLOT_I2C]   = aux_irq_prio_r[BIT_I2C];
    prio_vec[SLOT_USB]   = aux_irq_prio_r[BIT_USB];
  end

  // Live gated requests by slot
  always_comb begin
    live_req = '0;
    live_req[SLOT_EXT0]  = ext_request_zero_in;
    live_req[SLOT_UART2] = uart2_flag_in;
    live_req[SLOT_T0]    = timer0_flag_in;
    live_req[SLOT_I2C]   = i2c_flag_in;
    live_req[SLOT_EXT1]  = ext_request_one_in;
    live_req[SLOT_RSVD]  = 1'b0;
    live_req[SLOT_T1]    = timer1_flag_in;
    live_req[SLOT_USB]   = usb_flag_in;
    live_req[SLOT_UART]  = uart_flag_in;
    live_req[SLOT_T2]    = timer2_flag_in;
    live_req = live_req & en_vec
             & {NUM_SLOTS{main_irq_enable_r[BIT_GLOBAL]}};
  end

  assign mc_end     = (phase_r == MC_LAST);
  assign sample_now = (phase_r == SAMPLE_PHASE);

  // Machine-cycle phase counter and register port
  always_comb begin
    phase_nxt = mc_end ? 4'h0 : phase_r + 4'h1;
    main_irq_enable_nxt = main_irq_enable_r;
    aux_irq_enable_nxt  = aux_irq_enable_r;
    main_irq_prio_nxt   = main_irq_prio_r;
    aux_irq_prio_nxt    = aux_irq_prio_r;
    rdata_nxt           = 8'h00;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        ADDR_MAIN_EN:   main_irq_enable_nxt = reg_wdata_in & MAIN_EN_MASK;
        ADDR_AUX_EN:    aux_irq_enable_nxt  = reg_wdata_in & AUX_MASK;
        ADDR_MAIN_PRIO: main_irq_prio_nxt   = reg_wdata_in & MAIN_PRIO_MASK;
        ADDR_AUX_PRIO:  aux_irq_prio_nxt    = reg_wdata_in & AUX_MASK;
      endcase
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADDR_MAIN_EN:   rdata_nxt = main_irq_enable_r;
        ADDR_AUX_EN:    rdata_nxt = aux_irq_enable_r;
        ADDR_MAIN_PRIO: rdata_nxt = main_irq_prio_r;
        ADDR_AUX_PRIO:  rdata_nxt = aux_irq_prio_r;
      endcase
    end
  end

  // Sampling once per machine cycle, no memory of old requests
  always_comb begin
    sample_nxt = sample_r;
    if (sample_now) begin
      sample_nxt = live_req;
    end
  end

  tlic_arbiter u_arb (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .load_in      (sample_now),
    .req_in       (live_req),
    .prio_in      (prio_vec),
    .hit_out      (arb_hit),
    .hit_high_out (arb_high),
    .slot_out     (arb_slot)
  );

  // Blocking checks on the polled result
  assign allow = !high_active_r
               && !(low_active_r && !arb_high);
  assign take  = mc_end && arb_hit && allow
               && instr_last_cycle_in
               && !instr_blocks_in && !return_from_handler_in;

  // Call issue and in-progress tracking
  always_comb begin
    low_active_nxt  = low_active_r;
    high_active_nxt = high_active_r;
    call_nxt        = take;
    vec_nxt         = vec_r;
    clr0_nxt        = 1'b0;
    clr1_nxt        = 1'b0;
    wake_nxt        = core_idle_in && (|sample_r);
    if (return_from_handler_in && mc_end) begin
      if (high_active_r) high_active_nxt = 1'b0;
      else low_active_nxt = 1'b0;
    end
    if (take) begin
      vec_nxt = slot_vector(arb_slot);
      if (arb_high) high_active_nxt = 1'b1;
      else low_active_nxt = 1'b1;
      clr0_nxt = (arb_slot == SLOT_EXT0) && ext0_edge_mode_in;
      clr1_nxt = (arb_slot == SLOT_EXT1) && ext1_edge_mode_in;
    end
  end

  // State registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      main_irq_enable_r <= REG_RESET;
      aux_irq_enable_r  <= REG_RESET;
      main_irq_prio_r   <= REG_RESET;
      aux_irq_prio_r    <= REG_RESET;
      rdata_r           <= 8'h00;
      phase_r           <= 4'h0;
      sample_r          <= '0;
      low_active_r      <= 1'b0;
      high_active_r     <= 1'b0;
      call_r            <= 1'b0;
      vec_r             <= 16'h0000;
      clr0_r            <= 1'b0;
      clr1_r            <= 1'b0;
      wake_r            <= 1'b0;
    end else begin
      main_irq_enable_r <= main_irq_enable_nxt;
      aux_irq_enable_r  <= aux_irq_enable_nxt;
      main_irq_prio_r   <= main_irq_prio_nxt;
      aux_irq_prio_r    <= aux_irq_prio_nxt;
      rdata_r           <= rdata_nxt;
      phase_r           <= phase_nxt;
      sample_r          <= sample_nxt;
      low_active_r      <= low_active_nxt;
      high_active_r     <= high_active_nxt;
      call_r            <= call_nxt;
      vec_r             <= vec_nxt;
      clr0_r            <= clr0_nxt;
      clr1_r            <= clr1_nxt;
      wake_r            <= wake_nxt;
    end
  end

  assign reg_rdata_out            = rdata_r;
  assign hardware_vector_call_out = call_r;
  assign vector_addr_out          = vec_r;
  assign ext0_flag_clear_out      = clr0_r;
  assign ext1_flag_clear_out      = clr1_r;
  assign idle_wake_out            = wake_r;
  assign low_active_out           = low_active_r;
  assign high_active_out          = high_active_r;

  // Checks
  chk_no_call_high: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    high_active_r |=> !call_r) else $error("call while high active");
  chk_call_last: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    call_r |-> $past(instr_last_cycle_in) && $past(mc_end))
    else $error("call outside last cycle");
  chk_call_block: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (instr_blocks_in || return_from_handler_in) |=> !call_r)
    else $error("call during blocking instruction");
  chk_gate_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    call_r |-> $past(main_irq_enable_r[BIT_GLOBAL], 3))
    else $error("call with global gate off");
  chk_low_preempt: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (call_r && $past(low_active_r)) |-> high_active_r)
    else $error("low handler preempted by low");
  chk_vec_legal: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    call_r |-> (vec_r[2:0] == 3'h3 && vec_r <= VEC_UART2))
    else $error("illegal vector");
  chk_return_from_handler_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (return_from_handler_in && mc_end && high_active_r) |=> !high_active_r)
    else $error("return did not clear level");
  chk_edge_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ext0_flag_clear_out |-> call_r && vector_addr_out == VEC_EXT0)
    else $error("ext0 clear without call");
endmodule : tlic_ctrl

/* verification/tlic_core_model.sv */
// Core and request source model facing the interrupt controller
`timescale 1ns/100ps
module tlic_core_model (
  input  wire logic  clk_in,
  input  wire logic  call_in,
  input  wire logic  clr0_in,
  input  wire logic  clr1_in,
  output logic [9:0] flag_out,
  output logic       ret_out,
  output int         depth_out
);
  // Quiet core and sources at time zero
  initial begin
    flag_out = 10'h000;
    ret_out = 1'h0;
    depth_out = 0;
  end
  // Pushes on each call; a clear pulse drops the external flag
  always @(posedge clk_in) begin
    if (call_in) begin
      depth_out <= depth_out + 1;
    end
    if (clr0_in) begin
      flag_out[0] <= 1'h0;
    end
    if (clr1_in) begin
      flag_out[4] <= 1'h0;
    end
  end
  // Sources raise flags; the reserved slot has no source
  task automatic set(input logic [9:0] f);
    flag_out <= f & 10'h3DF;
  endtask
  // Return held one full machine cycle, then the stack pops
  task automatic do_return();
    ret_out <= 1'h1;
    repeat (12) @(posedge clk_in);
    ret_out <= 1'h0;
    depth_out <= depth_out - 1;
  endtask
endmodule // tlic_core_model

/* verification/tb.sv */
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/100ps
module tb;
  // Per polling slot: enable register, bit and vector
  localparam int SREG [10] = '{0, 1, 0, 1, 0, 0, 0, 1, 0, 0};
  localparam int SBIT [10] = '{0, 4, 1, 1, 2, 0, 3, 0, 4, 5};
  localparam logic [15:0] SVEC [10] = '{16'h0003, 16'h004B, 16'h000B,
    16'h0043, 16'h0013, 16'h0000, 16'h001B, 16'h0033, 16'h0023, 16'h002B};
  localparam logic [7:0] RMASK [4] = '{8'hBF, 8'h13, 8'h3F, 8'h13};
  logic        clk_in = 1'h0;
  logic        rst_n_in = 1'h0;
  logic [1:0]  addr = 2'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic        last = 1'h1;
  logic        blk = 1'h0;
  logic        idle = 1'h0;
  logic [1:0]  edge_md = 2'h3;
  logic        exp_lo = 1'h0;
  logic        exp_hi = 1'h0;
  logic [7:0]  rdata;
  logic [15:0] vec;
  logic [9:0]  flags;
  logic        call, clr0, clr1, wake, lo, hi, ret;
  int          depth;
  int          fail_count = 0;
  int          check_count = 0;
  int          calls = 0;
  int          sh [4] = '{0, 0, 0, 0};
  // Core clock, 4 ns period
  always #2 clk_in = ~clk_in;
  tlic_ctrl DUT (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .ext_request_zero_in(flags[0]),
    .ext_request_one_in(flags[4]), .ext0_edge_mode_in(edge_md[0]),
    .ext1_edge_mode_in(edge_md[1]), .timer0_flag_in(flags[2]),
    .timer1_flag_in(flags[6]), .timer2_flag_in(flags[9]),
    .uart_flag_in(flags[8]), .uart2_flag_in(flags[1]),
    .i2c_flag_in(flags[3]), .usb_flag_in(flags[7]),
    .instr_last_cycle_in(last), .instr_blocks_in(blk),
    .return_from_handler_in(ret), .core_idle_in(idle),
    .hardware_vector_call_out(call), .vector_addr_out(vec),
    .ext0_flag_clear_out(clr0), .ext1_flag_clear_out(clr1),
    .idle_wake_out(wake), .low_active_out(lo), .high_active_out(hi)
  );
  tlic_core_model core (
    .clk_in(clk_in), .call_in(call), .clr0_in(clr0), .clr1_in(clr1),
    .flag_out(flags), .ret_out(ret), .depth_out(depth)
  );
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One-cycle register write; shadow keeps the writable bits
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk_in);
    wr <= 1'h0;
    sh[a] = int'(d & RMASK[a]);
  endtask
  // One-cycle register read, data taken in the following cycle
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk_in);
    rd <= 1'h0;
    @(negedge clk_in);
    d = rdata;
  endtask
  // Source flags change on a rising edge
  task automatic raise(input logic [9:0] f);
    @(posedge clk_in);
    core.set(f);
  endtask
  // Reference arbitration from shadows and tracked levels
  function automatic int pick(input logic [9:0] f);
    if (exp_hi || blk || !last) begin
      return -1;
    end
    for (int l = 1; l >= 0; l--) begin
      if (l == 0 && exp_lo) begin
        return -1;
      end
      for (int s = 0; s < 10; s++) begin
        if (f[s] && s != 5 && sh[0][7] && sh[SREG[s]][SBIT[s]] &&
            sh[2 + SREG[s]][SBIT[s]] == l) begin
          return s;
        end
      end
    end
    return -1;
  endfunction
  // Bounded wait for a call, compared with the reference
  task automatic expect_call(input logic [9:0] f);
    int s;
    int n;
    @(negedge clk_in);
    s = pick(f);
    n = 0;
    while (call !== 1'h1 && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    check({15'h0, call}, {15'h0, s >= 0});
    if (s >= 0 && call !== 1'h1) begin
      summarize();
    end
    if (s >= 0) begin
      check(vec, SVEC[s]);
      if (sh[2 + SREG[s]][SBIT[s]]) begin
        exp_hi = 1'h1;
      end else begin
        exp_lo = 1'h1;
      end
      calls++;
      @(negedge clk_in);
      check({15'h0, call}, 16'h0000);
      check({14'h0, hi, lo}, {14'h0, exp_hi, exp_lo});
      check(depth[15:0], calls[15:0]);
      if (s == 0 || s == 4) begin
        check({15'h0, flags[s]}, {15'h0, !edge_md[s / 4]});
      end
    end
  endtask
  // Return from handler; the top active level leaves service
  task automatic finish_handler();
    @(posedge clk_in);
    core.do_return();
    calls--;
    if (exp_hi) begin
      exp_hi = 1'h0;
    end else begin
      exp_lo = 1'h0;
    end
    @(negedge clk_in);
    check({14'h0, hi, lo}, {14'h0, exp_hi, exp_lo});
  endtask
  // Hang guard
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
  // Main sequence
  initial begin
    logic [7:0] d;
    logic [7:0] b;
    logic [9:0] f;
    void'($urandom(32'hA64E7A13));
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'h1;
    // Reset values, then writable bits for ones and random data
    for (int i = 0; i < 12; i++) begin
      rd_reg(2'(i % 4), d);
      check({8'h00, d}, 16'(sh[i % 4]));
      wr_reg(2'(i % 4), i < 4 ? 8'hFF : 8'($urandom));
    end
    // Each source alone: gate off, own enable off, then taken
    wr_reg(2'h2, 8'h00);
    wr_reg(2'h3, 8'h00);
    for (int s = 0; s < 10; s++) begin
      b = 8'h01 << SBIT[s];
      wr_reg(2'h0, 8'h3F);
      wr_reg(2'h1, 8'h13);
      raise(10'h001 << s);
      expect_call(10'h001 << s);
      // Own enable drops before the gate opens (aux bits) or in the same write (main bits), so no stray call
      wr_reg(2'h1, SREG[s] == 1 ? 8'h13 & ~b : 8'h13);
      wr_reg(2'h0, SREG[s] == 1 ? 8'hBF : 8'hBF & ~b);
      expect_call(10'h001 << s);
      wr_reg(2'h0, 8'hBF);
      wr_reg(2'h1, 8'h13);
      expect_call(10'h001 << s);
      raise(10'h000);
      if (s != 5) begin
        finish_handler();
      end
    end
    // Random simultaneous requests, levels, enables and modes
    for (int i = 0; i < 12; i++) begin
      wr_reg(2'h0, 8'h80 | 8'($urandom));
      wr_reg(2'h1, 8'($urandom));
      wr_reg(2'h2, 8'($urandom));
      wr_reg(2'h3, 8'($urandom));
      edge_md <= 2'($urandom);
      f = 10'($urandom);
      raise(f);
      expect_call(f);
      raise(10'h000);
      if (exp_lo === 1'h1 || exp_hi === 1'h1) begin
        finish_handler();
      end
    end
    // Low handler preempted; nothing nests under a high handler
    wr_reg(2'h0, 8'hBF);
    wr_reg(2'h1, 8'h13);
    wr_reg(2'h2, 8'h02);
    wr_reg(2'h3, 8'h00);
    edge_md <= 2'h3;
    raise(10'h001);
    expect_call(10'h001);
    raise(10'h004);
    expect_call(10'h004);
    raise(10'h001);
    expect_call(10'h001);
    raise(10'h000);
    finish_handler();
    raise(10'h010);
    expect_call(10'h010);
    raise(10'h000);
    finish_handler();
    // Blocking and non-final cycles withhold; no memory kept
    @(posedge clk_in);
    blk <= 1'h1;
    raise(10'h004);
    expect_call(10'h004);
    raise(10'h000);
    repeat (24) @(posedge clk_in);
    blk <= 1'h0;
    expect_call(10'h000);
    @(posedge clk_in);
    last <= 1'h0;
    raise(10'h004);
    expect_call(10'h004);
    @(posedge clk_in);
    last <= 1'h1;
    expect_call(10'h004);
    raise(10'h000);
    finish_handler();
    // Idle core woken by an enabled request while calls are held
    @(posedge clk_in);
    blk <= 1'h1;
    idle <= 1'h1;
    raise(10'h200);
    for (int n = 0; n < 30 && wake !== 1'h1; n++) begin
      @(negedge clk_in);
    end
    check({15'h0, wake}, 16'h0001);
    check(depth[15:0], 16'h0000);
    raise(10'h000);
    idle <= 1'h0;
    repeat (24) @(posedge clk_in);
    blk <= 1'h0;
    @(negedge clk_in);
    check({15'h0, wake}, 16'h0000);
    summarize();
  end
endmodule // tb
